// ### ppcb_pad_pull_control_bank.sv
// Operation
// - Mask bit n+16 enables data bit n
// - Unmasked data bits keep previous value
// - Upper half is write-only mask, reads zero
// - Two bits per pad, eight pads per register
// - Codes: zero float, one up, two down
// - Code three selects bus keeper
// - Port2 group B resets to 0x959a
// - Port2 group C resets to 0x5565
// - Port2 group D resets to 0x55a5
// - Port3 group A resets to 0x55a5
// - Port3 group B resets to 0x5aaa
// - Port3 group C resets to 0x6555
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module ppcb_pad_pull_control_bank #(
  parameter int ADDR_W = 12
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  output logic      [15:0]       pull_field_port2_group_b,
  output logic      [15:0]       pull_field_port2_group_c,
  output logic      [15:0]       pull_field_port2_group_d,
  output logic      [15:0]       pull_field_port3_group_a,
  output logic      [15:0]       pull_field_port3_group_b,
  output logic      [15:0]       pull_field_port3_group_c,
  output logic      [7:0]        pad_pull_up_en [ppcb_pkg::NUM_REGS],
  output logic      [7:0]        pad_pull_down_en [ppcb_pkg::NUM_REGS],
  output logic      [7:0]        pad_keeper_en [ppcb_pkg::NUM_REGS]
);
  localparam int N = ppcb_pkg::NUM_REGS;
  localparam logic [15:0] RST_VALS [N] = '{
    ppcb_pkg::RST_P2B, ppcb_pkg::RST_P2C, ppcb_pkg::RST_P2D,
    ppcb_pkg::RST_P3A, ppcb_pkg::RST_P3B, ppcb_pkg::RST_P3C
  };
  localparam logic [11:0] OFFS [N] = '{
    ppcb_pkg::OFF_P2B, ppcb_pkg::OFF_P2C, ppcb_pkg::OFF_P2D,
    ppcb_pkg::OFF_P3A, ppcb_pkg::OFF_P3B, ppcb_pkg::OFF_P3C
  };

  logic        ack_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [15:0] field [N];
  logic [N-1:0] hit;
  logic [31:0] eff_word;
  logic        req;
  logic        wr_stb;

  // Single-beat request; ack only on the first cycle so each access
  // completes once even while the master still holds stb
  assign req    = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr_stb = req & wb_we_i;

  // Byte lanes 3 and 2 gate the mask; wb_sel_i[1:0] are ignored, so the data lanes are never gated
  assign eff_word = {wb_dat_i[31:24] & {8{wb_sel_i[3]}},
                     wb_dat_i[23:16] & {8{wb_sel_i[2]}},
                     wb_dat_i[15:0]};

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_reg
      assign hit[g] = (wb_adr_i[11:0] == OFFS[g]);
      // Reset values per group
      ppcb_mask_reg #(
        .RESET_VAL (RST_VALS[g])
      ) u_reg (
        .sys_clk (sys_clk),
        .rst     (rst),
        .wr_en   (wr_stb & hit[g]),
        .wr_word (eff_word),
        .value   (field[g])
      );
    end
  endgenerate

  // Read mux: upper half always zero, unmapped reads zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    for (int i = 0; i < N; i++) begin
      if (hit[i]) begin
        nxt_rdata = {16'h0000, field[i]};
      end
    end
  end

  // Bus answer registered; ack one cycle after the request is seen
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff   <= req;
      rdata_ff <= nxt_rdata;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  // Per-pad decode, registered so outputs come from flops
  logic [15:0] fld_ff [N];
  logic [7:0]  up_ff [N];
  logic [7:0]  dn_ff [N];
  logic [7:0]  kp_ff [N];
  logic [7:0]  nxt_up [N];
  logic [7:0]  nxt_dn [N];
  logic [7:0]  nxt_kp [N];

  generate
    for (g = 0; g < N; g++) begin : gen_dec
      genvar p;
      for (p = 0; p < 8; p++) begin : gen_pad
        // Pad p takes bits 2p+1:2p
        assign nxt_up[g][p] = field[g][2*p+1 -: 2] == ppcb_pkg::PULL_UP;
        assign nxt_dn[g][p] = field[g][2*p+1 -: 2] == ppcb_pkg::PULL_DOWN;
        assign nxt_kp[g][p] = field[g][2*p+1 -: 2] == ppcb_pkg::PULL_KEEPER;
      end
      // Pad controls lag the register by one cycle
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          fld_ff[g] <= RST_VALS[g];
          up_ff[g]  <= 8'h00;
          dn_ff[g]  <= 8'h00;
          kp_ff[g]  <= 8'h00;
        end else begin
          fld_ff[g] <= field[g];
          up_ff[g]  <= nxt_up[g];
          dn_ff[g]  <= nxt_dn[g];
          kp_ff[g]  <= nxt_kp[g];
        end
      end
      assign pad_pull_up_en[g]   = up_ff[g];
      assign pad_pull_down_en[g] = dn_ff[g];
      assign pad_keeper_en[g]    = kp_ff[g];
    end
  endgenerate

  assign pull_field_port2_group_b = fld_ff[0];
  assign pull_field_port2_group_c = fld_ff[1];
  assign pull_field_port2_group_d = fld_ff[2];
  assign pull_field_port3_group_a = fld_ff[3];
  assign pull_field_port3_group_b = fld_ff[4];
  assign pull_field_port3_group_c = fld_ff[5];
endmodule
`default_nettype wire

// ### ppcb_pkg.sv
`default_nettype none
package ppcb_pkg;
  // Register byte offsets
  localparam logic [11:0] OFF_P2B = 12'h0124;
  localparam logic [11:0] OFF_P2C = 12'h0128;
  localparam logic [11:0] OFF_P2D = 12'h012c;
  localparam logic [11:0] OFF_P3A = 12'h0130;
  localparam logic [11:0] OFF_P3B = 12'h0134;
  localparam logic [11:0] OFF_P3C = 12'h0138;
  // Reset values of the pull fields
  localparam logic [15:0] RST_P2B = 16'h959a;
  localparam logic [15:0] RST_P2C = 16'h5565;
  localparam logic [15:0] RST_P2D = 16'h55a5;
  localparam logic [15:0] RST_P3A = 16'h55a5;
  localparam logic [15:0] RST_P3B = 16'h5aaa;
  localparam logic [15:0] RST_P3C = 16'h6555;
  // Field layout
  localparam int DATA_W   = 16;
  localparam int MASK_LSB = 16;
  localparam int NUM_REGS = 6;
  // Pull mode encodings
  typedef enum logic [1:0] {
    PULL_NONE   = 2'h0,
    PULL_UP     = 2'h1,
    PULL_DOWN   = 2'h2,
    PULL_KEEPER = 2'h3
  } ppcb_pull_e;
endpackage
`default_nettype wire

// ### ppcb_mask_reg.sv
`timescale 1ns/1ps
`default_nettype none
module ppcb_mask_reg #(
  parameter logic [15:0] RESET_VAL = 16'h0000
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_word,
  output logic      [15:0] value
);
  logic [15:0] value_ff;
  logic [15:0] nxt_value;

  // Only bits whose mask bit is one take the new data; the rest hold
  assign nxt_value = (wr_word[31:16] & wr_word[15:0]) |
                     (~wr_word[31:16] & value_ff);
  assign value = value_ff;

  // Upper half is never stored, only the masked lower half
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      value_ff <= RESET_VAL;
    end else if (wr_en) begin
      value_ff <= nxt_value;
    end
  end
endmodule
`default_nettype wire

// ### ppcb_pad_pull_control_bank_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ppcb_chk #(parameter int ADDR_W = 12) (
  input wire logic              sys_clk,
  input wire logic              rst,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic [15:0]       pull_field_port2_group_b
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Field shadow lags one cycle, so the old value is still visible at ack
  wire logic [15:0] f = pull_field_port2_group_b;
  wire logic [15:0] m = wb_dat_i[31:16];
  wire logic [15:0] exp_b = m & wb_dat_i[15:0] | ~m & f;
  wire logic wr_b = wb_ack_o && wb_we_i && wb_adr_i == ppcb_pkg::OFF_P2B;
  wire logic rd = wb_ack_o && !wb_we_i;
  a_ack_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  a_ack_idle: assert property (!wb_stb_i |=> !wb_ack_o) else $error("stray ack");
  a_upper_zero: assert property (rd |-> wb_dat_o[31:16] == 16'h0000) else $error("mask read");
  a_mask_write: assert property (wr_b |=> f == $past(exp_b)) else $error("bad write");
  a_field_hold: assert property (!wb_ack_o |=> $stable(f)) else $error("field moved");
  a_unmap_zero: assert property (rd && wb_adr_i[11:8] != 4'h1 |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped data");
  a_reset_val: assert property ($fell(rst) |-> f == ppcb_pkg::RST_P2B) else $error("reset");
  c_write: cover property (wr_b);
  c_read: cover property (rd);
  c_reset: cover property ($fell(rst));
endmodule
bind ppcb_pad_pull_control_bank ppcb_chk #(.ADDR_W(ADDR_W)) u_chk (.sys_clk, .rst, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pull_field_port2_group_b);
`default_nettype wire

// ### ppcb_pad_pull_control_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ppcb_pad_pull_control_bank_tb;
  logic        sys_clk, rst, cyc, stb, we, ack;
  logic [11:0] adr;
  logic [31:0] dw, dr, r;
  logic [15:0] fb;
  logic [7:0]  pu [6], pd [6], kp [6];
  int          fails, n_compared;
  // Rows: six reset reads, then masked writes each followed by a read
  logic [11:0] ra [10] = '{12'h0124, 12'h0128, 12'h012c, 12'h0130, 12'h0134, 12'h0138,
    12'h0124, 12'h0124, 12'h0128, 12'h0200};
  logic [31:0] rw [4] = '{32'h0000_ffff, 32'h00ff_1234, 32'h0003_ffff, 32'hffff_ffff};
  logic [15:0] re [10] = '{16'h959a, 16'h5565, 16'h55a5, 16'h55a5, 16'h5aaa, 16'h6555,
    16'h959a, 16'h9534, 16'h5567, 16'h0000};
  ppcb_pad_pull_control_bank u_dut (.sys_clk, .rst, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dw), .wb_dat_o(dr),
    .wb_ack_o(ack), .pull_field_port2_group_b(fb), .pull_field_port2_group_c(),
    .pull_field_port2_group_d(), .pull_field_port3_group_a(), .pull_field_port3_group_b(),
    .pull_field_port3_group_c(), .pad_pull_up_en(pu), .pad_pull_down_en(pd),
    .pad_keeper_en(kp));
  // 200 MHz clock
  initial begin
    sys_clk = 1'h0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // A hang can only come from a missing ack; the run needs far fewer cycles
  initial begin
    repeat (2000) @(posedge sys_clk);
    fails++;
    results();
  end
  task chk(input logic [31:0] g, e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Single classic cycle, held until ack is sampled high
  task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {cyc, stb, we, adr, dw} <= {2'h3, w, a, d};
    do @(posedge sys_clk); while (ack !== 1'h1);
    r = dr;
    {cyc, stb} <= 2'h0;
  endtask
  task results();
    $display("fails=%0d compared=%0d", fails, n_compared);
    if (fails == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Main sequence
  initial begin
    rst = 1'h1;
    {cyc, stb, we, adr, dw} = '0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'h0;
    for (int i = 0; i < 10; i++) begin
      if (i > 5) acc(1'h1, ra[i], rw[i-6]);
      acc(1'h0, ra[i], 32'h0000_0000);
      chk(r, {16'h0000, re[i]});
    end
    // Group B 0x9534: pads 1,4,5,6 up, pad 7 down, pad 2 keeper
    chk(32'(fb), 32'h0000_9534);
    chk(32'(pu[0]), 32'h0000_0072);
    chk(32'(pd[0]), 32'h0000_0080);
    chk(32'(kp[0]), 32'h0000_0004);
    chk(32'(kp[1]), 32'h0000_0001);
    // Reset in mid-run restores the written group
    rst <= 1'h1;
    @(posedge sys_clk);
    rst <= 1'h0;
    @(posedge sys_clk);
    @(posedge sys_clk);
    // Look away from the edge so the flops have settled
    @(negedge sys_clk);
    chk(32'(fb), 32'h0000_959a);
    chk(32'(pu[0]), 32'h0000_0074);
    chk(32'(pd[0]), 32'h0000_008b);
    results();
  end
endmodule
`default_nettype wire
